// file: inc/sffe_pkg.sv
/*
  shared constants, types and decode functions of the serial flash front end.
  assumes a 100 MHz system clock; the serial clock comes from the host.
*/
package sffe_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 10;

  // frame layout: opcode then address, msb first
  localparam int OP_BITS    = 8;
  localparam int ADDR_BITS  = 24;
  localparam int HDR_BITS   = OP_BITS + ADDR_BITS;
  localparam int CNT_W      = 6;
  localparam int BYTE_BITS  = 8;

  // address formats
  localparam int PAGE_BITS      = 13;
  localparam int STD_BYTE_BITS  = 10;
  localparam int BIN_BYTE_BITS  = 9;
  localparam int BUF_AW         = STD_BYTE_BITS;
  localparam int MEM_AW         = BUF_AW + 1;
  localparam logic [BUF_AW-1:0] STD_LAST_BYTE = 10'h20f;
  localparam logic [BUF_AW-1:0] BIN_LAST_BYTE = 10'h1ff;

  // protection granularity
  localparam int SECT_SHIFT = 7;
  localparam int SECT_BITS  = PAGE_BITS - SECT_SHIFT;
  localparam int N_SECT     = 1 << SECT_BITS;

  // value shifted out for main-array reads (array contents live elsewhere)
  localparam logic [BYTE_BITS-1:0] ARRAY_FILL = 8'hff;

  // opcodes
  localparam logic [OP_BITS-1:0] OP_RD_ARRAY   = 8'h03;
  localparam logic [OP_BITS-1:0] OP_RD_BUF1    = 8'hd1;
  localparam logic [OP_BITS-1:0] OP_RD_BUF2    = 8'hd3;
  localparam logic [OP_BITS-1:0] OP_WR_BUF1    = 8'h84;
  localparam logic [OP_BITS-1:0] OP_WR_BUF2    = 8'h87;
  localparam logic [OP_BITS-1:0] OP_PROG_BUF1  = 8'h83;
  localparam logic [OP_BITS-1:0] OP_PROG_BUF2  = 8'h86;
  localparam logic [OP_BITS-1:0] OP_PG_ERASE   = 8'h81;
  localparam logic [OP_BITS-1:0] OP_BLK_ERASE  = 8'h50;
  localparam logic [OP_BITS-1:0] OP_SEC_ERASE  = 8'h7c;
  localparam logic [OP_BITS-1:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [OP_BITS-1:0] OP_XFER_BUF1  = 8'h53;
  localparam logic [OP_BITS-1:0] OP_XFER_BUF2  = 8'h55;
  localparam logic [OP_BITS-1:0] OP_CMP_BUF1   = 8'h60;
  localparam logic [OP_BITS-1:0] OP_CMP_BUF2   = 8'h61;
  localparam logic [OP_BITS-1:0] OP_PROT_EN    = 8'h3d;
  localparam logic [OP_BITS-1:0] OP_PROT_SET   = 8'h3f;
  localparam logic [OP_BITS-1:0] OP_LOCKDOWN   = 8'h30;

  // self-timed durations
  localparam int PROG_TIME_NS  = 40000;
  localparam int PGER_TIME_NS  = 35000;
  localparam int BLKER_TIME_NS = 60000;
  localparam int SECER_TIME_NS = 200000;
  localparam int CHIPER_TIME_NS = 1000000;
  localparam int XFER_TIME_NS  = 400;
  localparam int CMP_TIME_NS   = 400;
  localparam int PROG_CYC   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PGER_CYC   = PGER_TIME_NS / CLK_PERIOD_NS;
  localparam int BLKER_CYC  = BLKER_TIME_NS / CLK_PERIOD_NS;
  localparam int SECER_CYC  = SECER_TIME_NS / CLK_PERIOD_NS;
  localparam int CHIPER_CYC = CHIPER_TIME_NS / CLK_PERIOD_NS;
  localparam int XFER_CYC   = XFER_TIME_NS / CLK_PERIOD_NS;
  localparam int CMP_CYC    = CMP_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    CL_NONE, CL_RD_ARR, CL_RD_BUF, CL_WR_BUF, CL_PROG, CL_PG_ERASE,
    CL_BLK_ERASE, CL_SEC_ERASE, CL_CHIP_ERASE, CL_XFER, CL_CMP,
    CL_PROT_EN, CL_PROT_SET, CL_LOCK
  } sffe_class_t;

  typedef struct packed {
    logic [OP_BITS-1:0]   op;
    logic [ADDR_BITS-1:0] addr;
  } sffe_cmd_t;

  typedef struct packed {
    logic [PAGE_BITS-1:0] page_number;
    logic [BUF_AW-1:0]    byte_in_page;
  } sffe_loc_t;

  function automatic sffe_class_t sffe_classify(input logic [OP_BITS-1:0] op);
    case (op)
      OP_RD_ARRAY:                 return CL_RD_ARR;
      OP_RD_BUF1, OP_RD_BUF2:      return CL_RD_BUF;
      OP_WR_BUF1, OP_WR_BUF2:      return CL_WR_BUF;
      OP_PROG_BUF1, OP_PROG_BUF2:  return CL_PROG;
      OP_PG_ERASE:                 return CL_PG_ERASE;
      OP_BLK_ERASE:                return CL_BLK_ERASE;
      OP_SEC_ERASE:                return CL_SEC_ERASE;
      OP_CHIP_ERASE:               return CL_CHIP_ERASE;
      OP_XFER_BUF1, OP_XFER_BUF2:  return CL_XFER;
      OP_CMP_BUF1, OP_CMP_BUF2:    return CL_CMP;
      OP_PROT_EN:                  return CL_PROT_EN;
      OP_PROT_SET:                 return CL_PROT_SET;
      OP_LOCKDOWN:                 return CL_LOCK;
      default:                     return CL_NONE;
    endcase
  endfunction

  // buffer 2 selected (0 means buffer 1)
  function automatic logic sffe_op_buf(input logic [OP_BITS-1:0] op);
    return (op == OP_RD_BUF2) || (op == OP_WR_BUF2) || (op == OP_PROG_BUF2) ||
           (op == OP_XFER_BUF2) || (op == OP_CMP_BUF2);
  endfunction

  function automatic logic [BUF_AW-1:0] sffe_buf_addr(input logic [ADDR_BITS-1:0] a,
                                                     input logic bin);
    return bin ? {1'b0, a[BIN_BYTE_BITS-1:0]} : a[STD_BYTE_BITS-1:0];
  endfunction

  function automatic sffe_loc_t sffe_main_loc(input logic [ADDR_BITS-1:0] a,
                                             input logic bin);
    sffe_loc_t l;
    l.page_number  = bin ? a[BIN_BYTE_BITS+PAGE_BITS-1:BIN_BYTE_BITS]
                         : a[STD_BYTE_BITS+PAGE_BITS-1:STD_BYTE_BITS];
    l.byte_in_page = sffe_buf_addr(a, bin);
    return l;
  endfunction

endpackage

// file: src/sffe_sync2.sv
/*
  two-flop level synchroniser, one bit or a few independent levels.
  assumes each bit is a slow level; multi-bit words must be stable while read.
*/
`timescale 1ns/100ps
module sffe_sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= RST_VAL;
      q_out    <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule // sffe_sync2

// file: src/sffe_buf_mem.sv
/*
  the two page buffers as one byte memory, index {buffer, byte}.
  assumes one write and one read port on the serial clock; read data registered.
*/
`timescale 1ns/100ps
module sffe_buf_mem
  import sffe_pkg::*;
(
  input  wire logic                 clk_in,
  // write port
  input  wire logic                 we_in,
  input  wire logic [MEM_AW-1:0]    waddr_in,
  input  wire logic [BYTE_BITS-1:0] wdata_in,
  // read port
  input  wire logic [MEM_AW-1:0]    raddr_in,
  output logic      [BYTE_BITS-1:0] rdata_out
);
  logic [BYTE_BITS-1:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // sffe_buf_mem

// file: src/sffe_top.sv
/*
  serial flash front end: spi framing, buffer access, protection and busy engine.
  assumes a host in spi mode 0 or 3 on sck_in; array cells are outside this block.
*/
`timescale 1ns/100ps
module sffe_top
  import sffe_pkg::*;
#(
  parameter int PROG_CYCLES   = PROG_CYC,
  parameter int PGER_CYCLES   = PGER_CYC,
  parameter int BLKER_CYCLES  = BLKER_CYC,
  parameter int SECER_CYCLES  = SECER_CYC,
  parameter int CHIPER_CYCLES = CHIPER_CYC
) (
  // system clock and power-on reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // serial link
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  output logic      so_out,
  output logic      so_oe_out,
  // device pins
  input  wire logic wp_n_in,
  input  wire logic rst_n_in,
  output logic      rdy_busy_out,
  output logic      rdy_busy_oe_out,
  // configuration and status
  input  wire logic page_bin_in,
  output logic      busy_out,
  output logic      refused_out,
  output logic      sw_prot_en_out
);
  import sffe_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_BUSY = 3'b100
  } sffe_state_t;

  // ---------------- serial clock domain ----------------
  logic                 frame_rst;
  logic [CNT_W-1:0]     cnt_reg;
  logic [HDR_BITS-2:0]  hdr_reg;
  logic [HDR_BITS-1:0]  next_word;
  logic                 hdr_now;
  logic                 data_ph;
  sffe_class_t          cls_reg;
  sffe_class_t          cls_now;
  logic                 bsel_reg;
  logic [BUF_AW-1:0]    ptr_reg;
  logic [2:0]           dbit_reg;
  logic                 rd_en_reg;
  logic                 wr_en_reg;
  logic [6:0]           wshift_reg;
  logic [6:0]           so_shift_reg;
  logic                 launch_tgl_reg;
  sffe_cmd_t            hold_cmd_reg;
  logic [3:0]           s_sync;
  logic                 rdy_eng_any, rdy_eng_buf;
  logic                 busy_s, eng_any_s, eng_buf_s, bin_s;
  logic                 mem_we;
  logic [MEM_AW-1:0]    mem_raddr;
  logic [BYTE_BITS-1:0] mem_rdata;
  logic [BYTE_BITS-1:0] rd_byte;

  function automatic logic blk_buf(input logic b, input logic bsy, input logic any,
                                   input logic eb);
    return bsy && any && (eb == b);
  endfunction

  function automatic logic [BUF_AW-1:0] ptr_inc(input logic [BUF_AW-1:0] p,
                                               input logic bin);
    return (p == (bin ? BIN_LAST_BYTE : STD_LAST_BYTE)) ? '0 : p + 1'b1;
  endfunction

  assign frame_rst = sys_rst_in | cs_n_in | ~rst_n_in;
  assign {busy_s, eng_any_s, eng_buf_s, bin_s} = s_sync;
  assign next_word = {hdr_reg, si_in};
  assign hdr_now   = (cnt_reg == CNT_W'(HDR_BITS - 1));
  assign data_ph   = (cnt_reg == CNT_W'(HDR_BITS));
  assign cls_now   = sffe_classify(next_word[HDR_BITS-1:ADDR_BITS]);
  assign mem_we    = data_ph && wr_en_reg && (dbit_reg == 3'h7);
  assign mem_raddr = hdr_now ? {sffe_op_buf(next_word[HDR_BITS-1:ADDR_BITS]),
                                sffe_buf_addr(next_word[ADDR_BITS-1:0], bin_s)}
                             : {bsel_reg, ptr_inc(ptr_reg, bin_s)};
  assign rd_byte   = (cls_reg == CL_RD_ARR) ? ARRAY_FILL : mem_rdata;

  sffe_sync2 #(.W(4), .RST_VAL(4'h0)) u_sync_sck (
    .clk_in (sck_in),
    .rst_in (sys_rst_in),
    .d_in   ({busy_out, rdy_eng_any, rdy_eng_buf, page_bin_in}),
    .q_out  (s_sync)
  );

  sffe_buf_mem u_bufs (
    .clk_in    (sck_in),
    .we_in     (mem_we),
    .waddr_in  ({bsel_reg, ptr_reg}),
    .wdata_in  ({wshift_reg, si_in}),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  always_ff @(posedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_reg <= '0;
      hdr_reg <= '0;
    end else begin
      hdr_reg <= next_word[HDR_BITS-2:0];
      if (!data_ph) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // data phase setup and buffer pointer
  always_ff @(posedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      cls_reg    <= CL_NONE;
      bsel_reg   <= 1'b0;
      ptr_reg    <= '0;
      dbit_reg   <= '0;
      rd_en_reg  <= 1'b0;
      wr_en_reg  <= 1'b0;
      wshift_reg <= '0;
    end else if (hdr_now) begin
      cls_reg   <= cls_now;
      bsel_reg  <= sffe_op_buf(next_word[HDR_BITS-1:ADDR_BITS]);
      ptr_reg   <= sffe_buf_addr(next_word[ADDR_BITS-1:0], bin_s);
      dbit_reg  <= '0;
      rd_en_reg <= ((cls_now == CL_RD_BUF) &&
                    !blk_buf(sffe_op_buf(next_word[HDR_BITS-1:ADDR_BITS]),
                             busy_s, eng_any_s, eng_buf_s)) ||
                   ((cls_now == CL_RD_ARR) && !busy_s);
      wr_en_reg <= (cls_now == CL_WR_BUF) &&
                   !blk_buf(sffe_op_buf(next_word[HDR_BITS-1:ADDR_BITS]),
                            busy_s, eng_any_s, eng_buf_s);
    end else if (data_ph) begin
      dbit_reg   <= dbit_reg + 1'b1;
      wshift_reg <= {wshift_reg[5:0], si_in};
      if (dbit_reg == 3'h7) begin
        ptr_reg <= ptr_inc(ptr_reg, bin_s);
      end
    end
  end

  // output shifts on falling sck, first byte after the header
  always_ff @(negedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      so_out       <= 1'b0;
      so_oe_out    <= 1'b0;
      so_shift_reg <= '0;
    end else if (rd_en_reg) begin
      so_oe_out <= 1'b1;
      if (dbit_reg == 3'h0) begin
        {so_out, so_shift_reg} <= rd_byte;
      end else begin
        {so_out, so_shift_reg} <= {so_shift_reg, 1'b0};
      end
    end
  end

  // only a full header hands a command over
  always_ff @(posedge sck_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      launch_tgl_reg <= 1'b0;
      hold_cmd_reg   <= '0;
    end else if (hdr_now && (cls_now inside {CL_PROG, CL_PG_ERASE, CL_BLK_ERASE,
                 CL_SEC_ERASE, CL_CHIP_ERASE, CL_XFER, CL_CMP, CL_PROT_EN,
                 CL_PROT_SET, CL_LOCK})) begin
      launch_tgl_reg <= ~launch_tgl_reg;
      hold_cmd_reg   <= next_word;
    end
  end

  // ---------------- system clock domain ----------------
  logic [4:0]        c_sync;
  logic              cs_n_s, rst_n_s, wp_n_s, tgl_s, bin_c;
  logic              seen_reg;
  sffe_cmd_t         cmd_reg;
  sffe_class_t       cls_c;
  sffe_loc_t         loc_c;
  logic [SECT_BITS-1:0] sect_c;
  sffe_state_t       state_reg;
  logic [31:0]       timer_reg;
  logic [N_SECT-1:0] sect_prot_reg;
  logic [N_SECT-1:0] lock_reg;
  logic              is_mod, prot_hit, go;

  sffe_sync2 #(.W(5), .RST_VAL(5'h1c)) u_sync_clk (
    .clk_in (clk_in),
    .rst_in (sys_rst_in),
    .d_in   ({cs_n_in, rst_n_in, wp_n_in, launch_tgl_reg, page_bin_in}),
    .q_out  (c_sync)
  );

  assign {cs_n_s, rst_n_s, wp_n_s, tgl_s, bin_c} = c_sync;
  assign cls_c  = sffe_classify(cmd_reg.op);
  assign loc_c  = sffe_main_loc(cmd_reg.addr, bin_c);
  assign sect_c = loc_c.page_number[PAGE_BITS-1:SECT_SHIFT];
  // page program and four erase sizes
  assign is_mod = cls_c inside {CL_PROG, CL_PG_ERASE, CL_BLK_ERASE, CL_SEC_ERASE,
                                CL_CHIP_ERASE};
  assign prot_hit = (cls_c == CL_CHIP_ERASE)
                  ? (|lock_reg) || (sw_prot_en_out && (|sect_prot_reg))
                  : lock_reg[sect_c] || (sw_prot_en_out && sect_prot_reg[sect_c]);
  assign go = (state_reg == ST_WAIT) && cs_n_s && rst_n_s;

  function automatic logic [31:0] op_cycles(input sffe_class_t c);
    case (c)
      CL_PROG:       return 32'(PROG_CYCLES);
      CL_PG_ERASE:   return 32'(PGER_CYCLES);
      CL_BLK_ERASE:  return 32'(BLKER_CYCLES);
      CL_SEC_ERASE:  return 32'(SECER_CYCLES);
      CL_CHIP_ERASE: return 32'(CHIPER_CYCLES);
      CL_XFER:       return 32'(XFER_CYC);
      default:       return 32'(CMP_CYC);
    endcase
  endfunction

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg       <= ST_IDLE;
      seen_reg        <= 1'b0;
      cmd_reg         <= '0;
      timer_reg       <= '0;
      rdy_eng_any     <= 1'b0;
      rdy_eng_buf     <= 1'b0;
      busy_out        <= 1'b0;
      rdy_busy_oe_out <= 1'b0;
      refused_out     <= 1'b0;
    end else begin
      refused_out <= 1'b0;
      if (!rst_n_s) begin
        state_reg       <= ST_IDLE;
        seen_reg        <= tgl_s;
        busy_out        <= 1'b0;
        rdy_busy_oe_out <= 1'b0;
        rdy_eng_any     <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (tgl_s != seen_reg) begin
              seen_reg  <= tgl_s;
              cmd_reg   <= hold_cmd_reg;
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (go) begin
              if (is_mod && (!wp_n_s || prot_hit)) begin
                refused_out <= 1'b1;
                state_reg   <= ST_IDLE;
              end else if (is_mod || cls_c inside {CL_XFER, CL_CMP}) begin
                timer_reg       <= op_cycles(cls_c) - 32'h1;
                rdy_eng_any     <= cls_c inside {CL_PROG, CL_XFER, CL_CMP};
                rdy_eng_buf     <= sffe_op_buf(cmd_reg.op);
                busy_out        <= 1'b1;
                rdy_busy_oe_out <= 1'b1;
                state_reg       <= ST_BUSY;
              end else begin
                refused_out <= (cls_c == CL_PROT_SET) && !wp_n_s;
                state_reg   <= ST_IDLE;
              end
            end
          end
          ST_BUSY: begin
            if (tgl_s != seen_reg) begin
              seen_reg    <= tgl_s;
              refused_out <= 1'b1;
            end
            if (timer_reg == 32'h0) begin
              busy_out        <= 1'b0;
              rdy_busy_oe_out <= 1'b0;
              rdy_eng_any     <= 1'b0;
              state_reg       <= ST_IDLE;
            end else begin
              timer_reg <= timer_reg - 32'h1;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sect_prot_reg  <= '0;
      lock_reg       <= '0;
      sw_prot_en_out <= 1'b0;
    end else if (go) begin
      if (cls_c == CL_PROT_EN) begin
        sw_prot_en_out <= 1'b1;
      end
      if (cls_c == CL_LOCK) begin
        lock_reg[sect_c] <= 1'b1;
      end
      if ((cls_c == CL_PROT_SET) && wp_n_s) begin
        sect_prot_reg[sect_c] <= 1'b1;
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdy_busy_out <= 1'b0;
    end else begin
      rdy_busy_out <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  chk_float_header: assert property (@(posedge sck_in) disable iff (sys_rst_in)
    !data_ph |-> !so_oe_out) else $error("serial output driven during header");
  chk_full_header: assert property (@(posedge sck_in) disable iff (sys_rst_in)
    (!hdr_now && !cs_n_in) |=> $stable(launch_tgl_reg))
    else $error("command handed over without a full header");
  chk_buf_blocked: assert property (@(posedge sck_in) disable iff (sys_rst_in)
    !(mem_we && blk_buf(bsel_reg, busy_s, eng_any_s, eng_buf_s)))
    else $error("write to engaged buffer while busy");
  chk_wp_discard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (go && is_mod && !wp_n_s) |=> (!busy_out && refused_out))
    else $error("modifying command ran under write protect");
  chk_prot_frozen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wp_n_s |=> $stable(sect_prot_reg)) else $error("protection changed under wp");
  chk_prot_en_wp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (go && cls_c == CL_PROT_EN) |=> sw_prot_en_out)
    else $error("protection enable not accepted");
  chk_reset_abort: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !rst_n_s |=> (state_reg == ST_IDLE) && !rdy_busy_oe_out)
    else $error("reset pin did not abort");
  chk_busy_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(rdy_busy_oe_out) |-> $past(go) && $past(state_reg == ST_WAIT) && busy_out)
    else $error("busy pin rose without a launched operation");
  chk_busy_end: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_reg == ST_BUSY && timer_reg == 32'h0 && rst_n_s) |=> !rdy_busy_oe_out)
    else $error("busy pin held after operation end");

endmodule // sffe_top

// file: bench/sffe_host_model.sv
/*
  spi host model: one frame per call, sck of 12 ns period, mode 0 or 3.
  assumes the device takes si on rising sck and moves so on falling sck.
*/
`timescale 1ns/100ps
module sffe_host_model (
  // serial link
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
  end
  // nbits header bits, then one data byte once the header is whole
  task automatic frame(input logic [31:0] hdr, input int nbits, input logic [7:0] wd,
                       input logic m3, output logic [7:0] rd, output logic oe);
    rd = 8'h00;
    oe = 1'b0;
    sck_out = m3;
    // select falls first, sck idles at the mode level
    #6 cs_n_out = 1'b0;
    // one bit per sck, set on the falling half, msb first
    for (int i = 0; i < nbits; i++) begin
      sck_out = 1'b0;
      si_out  = hdr[31-i];
      #6 sck_out = 1'b1;
      #6;
    end
    for (int i = 0; i < 8 && nbits == 32; i++) begin
      sck_out = 1'b0;
      si_out  = wd[7-i];
      #6 sck_out = 1'b1;
      rd[7-i] = so_in;
      oe      = oe | so_oe_in;
      #6;
    end
    sck_out = m3;
    #6 cs_n_out = 1'b1;
    // released line shows the inverse of its last value
    si_out = ~si_out;
    // select stays high long enough for the system clock to see it
    #36;
  endtask
endmodule // sffe_host_model

// file: bench/sffe_top_bench.sv
/*
  bench of the serial flash front end: host model on the link, pins driven here.
  assumes shortened self-timed counts set through the top parameters.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module sffe_top_bench;
  import sffe_pkg::*;
  localparam int PGN = 300;
  logic clk_in, sys_rst_in, sck, cs_n, si, so, so_oe, wp_n, rst_n, bin;
  logic rb, rb_oe, busy, refused, sw_en, oe;
  logic [7:0] rd;
  int bad_count, total_checks, ref_n, busy_n;
  sffe_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
                          .so_oe_in(so_oe));
  sffe_top #(.PROG_CYCLES(40), .PGER_CYCLES(PGN), .BLKER_CYCLES(40), .SECER_CYCLES(40),
             .CHIPER_CYCLES(40)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .wp_n_in(wp_n), .rst_n_in(rst_n), .rdy_busy_out(rb), .rdy_busy_oe_out(rb_oe),
    .page_bin_in(bin), .busy_out(busy), .refused_out(refused), .sw_prot_en_out(sw_en));
  always @(posedge clk_in) begin
    ref_n  <= ref_n + int'(refused === 1'b1);
    busy_n <= busy_n + int'(busy === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] wd,
                     input logic m3);
    u_host.frame({op, a}, 32, wd, m3, rd, oe);
  endtask
  task automatic wait_busy;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
  endtask
  task automatic t_reset;
    `CHK(busy, 1'b0)
    `CHK(rb_oe, 1'b0)
    `CHK(so_oe, 1'b0)
    `CHK(sw_en, 1'b0)
  endtask
  task automatic t_buffers;
    for (int m = 0; m < 2; m++) begin
      cmd(OP_WR_BUF1, 24'h00020f, 8'ha5 ^ 8'(m), m[0]);
      cmd(OP_RD_BUF1, 24'h00fe0f, 8'h00, m[0]);
      `CHK(rd, 8'ha5 ^ 8'(m))
      `CHK(oe, 1'b1)
      `CHK(so_oe, 1'b0)
    end
    cmd(OP_WR_BUF2, 24'h00020f, 8'h3c, 1'b1);
    cmd(OP_RD_BUF1, 24'h00020f, 8'h00, 1'b0);
    `CHK(rd, 8'ha4)
    cmd(OP_RD_BUF2, 24'h00020f, 8'h00, 1'b0);
    `CHK(rd, 8'h3c)
    cmd(OP_RD_ARRAY, 24'h000000, 8'h00, 1'b1);
    `CHK(rd, ARRAY_FILL)
    tick(1);
    bin = 1'b1;
    cmd(OP_WR_BUF1, 24'h0001ff, 8'h69, 1'b0);
    cmd(OP_RD_BUF1, 24'h0003ff, 8'h00, 1'b0);
    `CHK(rd, 8'h69)
    tick(1);
    bin = 1'b0;
  endtask
  task automatic t_erase;
    int b0;
    cmd(OP_PG_ERASE, 24'h000000, 8'h00, 1'b0);
    b0 = busy_n;
    wait_busy();
    `CHK(rb_oe, 1'b1)
    `CHK(rb, 1'b0)
    cmd(OP_RD_BUF2, 24'h00020f, 8'h00, 1'b0);
    `CHK(rd, 8'h3c)
    cmd(OP_RD_ARRAY, 24'h000000, 8'h00, 1'b0);
    `CHK(oe, 1'b0)
    tick(PGN);
    `CHK(busy_n - b0, PGN)
    `CHK(rb_oe, 1'b0)
  endtask
  task automatic t_wp;
    int r0;
    tick(1);
    r0 = ref_n;
    wp_n = 1'b0;
    tick(4);
    cmd(OP_PG_ERASE, 24'h000000, 8'h00, 1'b0);
    tick(10);
    `CHK(busy, 1'b0)
    `CHK(ref_n - r0, 1)
    cmd(OP_PROT_SET, 24'h000000, 8'h00, 1'b0);
    cmd(OP_PROT_EN, 24'h000000, 8'h00, 1'b0);
    cmd(OP_LOCKDOWN, 24'h000000, 8'h00, 1'b0);
    tick(10);
    `CHK(ref_n - r0, 2)
    `CHK(sw_en, 1'b1)
    wp_n = 1'b1;
    tick(4);
    cmd(OP_PG_ERASE, 24'h01fc00, 8'h00, 1'b0);
    tick(10);
    `CHK(ref_n - r0, 3)
    cmd(OP_PG_ERASE, 24'h020000, 8'h00, 1'b0);
    wait_busy();
    `CHK(busy, 1'b1)
    tick(PGN + 2);
  endtask
  task automatic t_partial;
    int r0;
    r0 = ref_n;
    u_host.frame({OP_PG_ERASE, 24'h000000}, 20, 8'h00, 1'b0, rd, oe);
    tick(10);
    `CHK(busy, 1'b0)
    `CHK(ref_n - r0, 0)
  endtask
  task automatic t_rst;
    cmd(OP_PG_ERASE, 24'h100000, 8'h00, 1'b0);
    wait_busy();
    rst_n = 1'b0;
    tick(5);
    `CHK(busy, 1'b0)
    cmd(OP_RD_BUF1, 24'h00020f, 8'h00, 1'b0);
    `CHK(oe, 1'b0)
    tick(1);
    rst_n = 1'b1;
    tick(5);
    `CHK(rb_oe, 1'b0)
  endtask
  task automatic end_of_test;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    bad_count = 0;
    total_checks = 0;
    ref_n = 0;
    busy_n = 0;
    sys_rst_in = 1'b1;
    wp_n = 1'b1;
    rst_n = 1'b1;
    bin = 1'b0;
    tick(5);
    sys_rst_in = 1'b0;
    tick(4);
    t_reset();
    t_buffers();
    t_erase();
    t_wp();
    t_partial();
    t_rst();
    end_of_test();
  end
endmodule // sffe_top_bench
